// [core/flag_pkg.sv]
package flag_pkg;

   localparam int FLAG_W = 16;
   localparam int PIN_W  = 13;

   // register offsets
   localparam logic [8:0] ADDR_DIR = 9'h1C1;
   localparam logic [8:0] ADDR_POL = 9'h1C2;
   localparam logic [8:0] ADDR_SRC = 9'h1C3;
   localparam logic [8:0] ADDR_ID  = 9'h1D5;

   // reset values and implemented-bit masks
   localparam logic [15:0] DIR_RST       = 16'h1FFF;
   localparam logic [15:0] SRC_RST       = 16'h1207;
   localparam logic [15:0] POL_RST       = 16'h0000;
   localparam logic [15:0] DIR_MASK      = 16'h1FFF;
   localparam logic [15:0] POL_MASK      = 16'h1FFF;
   localparam logic [15:0] SRC_MASK      = 16'h1FF8;
   localparam logic [15:0] FIXED_IO_MASK = 16'h0007;
   localparam logic [15:0] INTERNAL_MASK = 16'hE000;

   // identification field positions
   localparam int ID_PART_LSB  = 8;
   localparam int ID_LAYOUT_LSB = 4;
   localparam int ID_ISV_LSB   = 0;

   // fixed flag positions of the pins
   localparam int POS_GENERAL_FLAG_PIN0       = 0;
   localparam int POS_TRIGGER_PIN1            = 3;
   localparam int POS_INTERRUPT_REQUEST_PIN_N = 9;
   localparam int POS_AMPLIFIER_OUTPUT_PIN1   = 10;
   localparam int POS_TRACE_PIN               = 12;

   // glitch filter time, specified against a 24 MHz reference clock
   localparam int FILTER_TIME_NS = 125;
   localparam int FILTER_REF_MHZ = 24;
   localparam int FILTER_CYCLES  = (FILTER_TIME_NS * FILTER_REF_MHZ + 999) / 1000;

   // pins handed over to the flag bus: configurable bits plus the fixed i/o bits
   function automatic logic [15:0] pin_owned(input logic [15:0] src);
      pin_owned = (src & SRC_MASK) | FIXED_IO_MASK;
   endfunction

endpackage

// [core/flag_cfg_if.sv]
interface flag_cfg_if;
   logic [15:0] dir;
   logic [15:0] src;
   logic [15:0] pol;
   modport regs (output dir, output src, output pol);
   modport user (input dir, input src, input pol);
endinterface

// [core/flag_pin_filter.sv]
module flag_pin_filter
   import flag_pkg::*;
#(
   parameter int W = PIN_W,
   parameter int N = FILTER_CYCLES
) (
   input  wire logic         i_clk,
   input  wire logic         i_rstn,
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_filt
);

   typedef struct packed {
      logic [W-1:0]        s1;
      logic [W-1:0]        s2;
      logic [N-1:0][W-1:0] hist;
      logic [W-1:0]        out;
   } filt_state_t;

   filt_state_t st;
   filt_state_t next_st;
   logic [W-1:0] agree;

   //////////////////////////////////////////////////////////////////////////////
   always_comb begin
      agree = '1;
      for (int k = 1; k < N; k++) begin
         agree = agree & ~(st.hist[k] ^ st.hist[0]);
      end
      next_st      = st;
      next_st.s1   = i_pin;
      next_st.s2   = st.s1;
      next_st.hist = {st.hist[N-2:0], st.s2};
      // a level must sit in every history stage before it is taken
      next_st.out  = (agree & st.hist[0]) | (~agree & st.out);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_filt = st.out;

   //////////////////////////////////////////////////////////////////////////////
   glitch_reject_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      ((st.out ^ $past(st.out)) & ~$past(agree)) == '0)
      else $error("filtered flag moved without a stable history");

endmodule

// [core/flag_reg_file.sv]
module flag_reg_file
   import flag_pkg::*;
#(
   parameter logic [7:0] PART_ID    = 8'h5A, // arbitrary value
   parameter logic [3:0] LAYOUT_VER = 4'h1,
   parameter logic [3:0] ISV        = 4'h1
) (
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic [8:0]  i_addr,
   input  wire logic        i_wr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_rd,
   input  wire logic        i_lock,
   output logic      [15:0] o_rdata,
   output logic             o_rvalid,
   flag_cfg_if.regs         cfg
);

   typedef struct packed {
      logic [15:0] dir;
      logic [15:0] src;
      logic [15:0] pol;
      logic [15:0] rdata;
      logic        rvalid;
   } reg_state_t;

   localparam reg_state_t REG_RST = '{dir: DIR_RST, src: SRC_RST & SRC_MASK,
                                      pol: POL_RST, rdata: 16'h0000, rvalid: 1'b0};

   reg_state_t st;
   reg_state_t next_st;
   logic       wr_ok;
   logic [15:0] id_word;

   //////////////////////////////////////////////////////////////////////////////
   always_comb begin
      id_word = {PART_ID, LAYOUT_VER, ISV};
      // locked registers silently drop writes
      wr_ok   = i_wr && !i_lock;
      next_st = st;
      next_st.rvalid = i_rd;
      if (wr_ok && i_addr == ADDR_DIR) begin
         next_st.dir = i_wdata & DIR_MASK;
      end
      if (wr_ok && i_addr == ADDR_SRC) begin
         next_st.src = i_wdata & SRC_MASK;
      end
      if (wr_ok && i_addr == ADDR_POL) begin
         next_st.pol = i_wdata & POL_MASK;
      end
      unique case (i_addr)
         ADDR_DIR: next_st.rdata = st.dir;
         ADDR_SRC: next_st.rdata = st.src | FIXED_IO_MASK;
         ADDR_POL: next_st.rdata = st.pol;
         ADDR_ID:  next_st.rdata = id_word;
         default:  next_st.rdata = 16'h0000;
      endcase
      if (!i_rd) begin
         next_st.rdata = 16'h0000;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         st <= REG_RST;
      end else begin
         st <= next_st;
      end
   end

   assign o_rdata  = st.rdata;
   assign o_rvalid = st.rvalid;
   assign cfg.dir  = st.dir;
   assign cfg.src  = st.src;
   assign cfg.pol  = st.pol;

   //////////////////////////////////////////////////////////////////////////////
   lock_holds_cfg_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_lock && i_wr) |=> ($stable(st.dir) && $stable(st.src) && $stable(st.pol)))
      else $error("locked register changed on a write");

   dir_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_wr && !i_lock && i_addr == ADDR_DIR) |=> st.dir == ($past(i_wdata) & DIR_MASK))
      else $error("direction write not taken");

   src_width_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (st.src & ~SRC_MASK) == 16'h0000)
      else $error("source register holds bits outside flags 3 to 12");

   id_read_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_rd && i_addr == ADDR_ID) |=> (o_rvalid && o_rdata == {PART_ID, LAYOUT_VER, ISV}))
      else $error("identification read returned wrong word");

   lock_write_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
      i_lock && i_wr && i_addr == ADDR_SRC);

endmodule

// [core/flag_pin_router.sv]
// Functional notes
// - internal flags are the bitwise AND of both channels' flag outputs.
// - sixteen-bit flag bus goes to both channels; one shared copy serves both.
// - pins 3 to 12 routable; default original function takes internal flag, except pins 9 and 12, which reset routes as flags.
// - pin used as flag loses original function, fixed bus position only.
// - input flag overwrites bus through filter needing three stable clocks.
// - output flag: bus from internal flag, which also drives the pin.
// - top three flags have no pin, only channel exchange, not configurable.
// - bottom three flags always pin i/o; direction only, no source bit.
// - positions: 0-2 flags, 3-8 triggers, 9 irq, 10-11 amplifiers, 12 trace.
// - source register holds one bit each for flags 3 to 12.
// - direction register bits 0 to 12, effective only when pin routed.
// - source 0: pin keeps own function, bus follows internal flag.
// - source 1, direction 0: output flag from internal flag.
// - source 1, direction 1: input flag, bus from filtered pin.
// - read-only id word: part id, layout version, instruction-set version.
// - while locked, writes to source, direction and polarity are ignored.
// - polarity bit inverts a flag only where it meets a pin.
module flag_pin_router
   import flag_pkg::*;
#(
   parameter logic [7:0] PART_ID    = 8'h5A, // arbitrary value
   parameter logic [3:0] LAYOUT_VER = 4'h1,
   parameter logic [3:0] ISV        = 4'h1
) (
   input  wire logic              I_CLK_SYS,
   input  wire logic              I_RSTN,
   input  wire logic [FLAG_W-1:0] I_CH1_FLAGS,
   input  wire logic [FLAG_W-1:0] I_CH2_FLAGS,
   output logic      [FLAG_W-1:0] O_FLAG_BUS,
   input  wire logic [PIN_W-1:0]  I_FLAG_PIN,
   output logic      [PIN_W-1:0]  O_FLAG_PIN,
   output logic      [PIN_W-1:0]  O_FLAG_PIN_OE,
   output logic      [PIN_W-1:0]  O_PIN_IS_FLAG,
   input  wire logic [8:0]        I_REG_ADDR,
   input  wire logic              I_REG_WR,
   input  wire logic [15:0]       I_REG_WDATA,
   input  wire logic              I_REG_RD,
   input  wire logic              I_DEV_LOCK,
   output logic      [15:0]       O_REG_RDATA,
   output logic                   O_REG_RVALID
);

   typedef struct packed {
      logic [FLAG_W-1:0] bus;
      logic [PIN_W-1:0]  pin_out;
      logic [PIN_W-1:0]  pin_oe;
      logic [PIN_W-1:0]  pin_is_flag;
   } route_state_t;

   route_state_t      st;
   route_state_t      next_st;
   logic [FLAG_W-1:0] int_flags;
   logic [FLAG_W-1:0] owned;
   logic [FLAG_W-1:0] in_mode;
   logic [FLAG_W-1:0] out_mode;
   logic [PIN_W-1:0]  filt;

   flag_cfg_if cfg_bus ();

   default clocking cb_sys @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RSTN);

   //////////////////////////////////////////////////////////////////////////////
   flag_reg_file #(
      .PART_ID    (PART_ID),
      .LAYOUT_VER (LAYOUT_VER),
      .ISV        (ISV)
   ) u_regs (
      .i_clk    (I_CLK_SYS),
      .i_rstn   (I_RSTN),
      .i_addr   (I_REG_ADDR),
      .i_wr     (I_REG_WR),
      .i_wdata  (I_REG_WDATA),
      .i_rd     (I_REG_RD),
      .i_lock   (I_DEV_LOCK),
      .o_rdata  (O_REG_RDATA),
      .o_rvalid (O_REG_RVALID),
      .cfg      (cfg_bus.regs)
   );

   flag_pin_filter #(
      .W (PIN_W),
      .N (FILTER_CYCLES)
   ) u_filter (
      .i_clk  (I_CLK_SYS),
      .i_rstn (I_RSTN),
      .i_pin  (I_FLAG_PIN),
      .o_filt (filt)
   );

   //////////////////////////////////////////////////////////////////////////////
   always_comb begin
      int_flags = I_CH1_FLAGS & I_CH2_FLAGS;
      // bit i of pin vector sits at bus position i; no remap exists
      owned     = pin_owned(cfg_bus.src);
      in_mode   = owned & cfg_bus.dir & DIR_MASK;
      out_mode  = owned & ~cfg_bus.dir & DIR_MASK;
      next_st   = st;
      for (int i = 0; i < FLAG_W; i++) begin
         // upper bits and non-owned pins simply carry the internal flag
         next_st.bus[i] = int_flags[i];
      end
      for (int i = 0; i < PIN_W; i++) begin
         if (in_mode[i]) begin
            next_st.bus[i] = filt[i] ^ cfg_bus.pol[i];
         end
         next_st.pin_out[i]     = int_flags[i] ^ cfg_bus.pol[i];
         next_st.pin_oe[i]      = out_mode[i];
         next_st.pin_is_flag[i] = owned[i];
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RSTN) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // same bus copy serves both channels, which read it as their input
   assign O_FLAG_BUS    = st.bus;
   assign O_FLAG_PIN    = st.pin_out;
   assign O_FLAG_PIN_OE = st.pin_oe;
   assign O_PIN_IS_FLAG = st.pin_is_flag;

   //////////////////////////////////////////////////////////////////////////////
   upper_exchange_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      1'b1 |=> O_FLAG_BUS[15:13] == $past(I_CH1_FLAGS[15:13] & I_CH2_FLAGS[15:13]))
      else $error("upper flags not the AND of both channels");

   default_route_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      !cfg_bus.src[POS_TRACE_PIN] |=> (O_FLAG_BUS[POS_TRACE_PIN] ==
         $past(I_CH1_FLAGS[POS_TRACE_PIN] & I_CH2_FLAGS[POS_TRACE_PIN])
         && !O_FLAG_PIN_OE[POS_TRACE_PIN]))
      else $error("unrouted pin did not keep internal flag");

   pin_released_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      !cfg_bus.src[POS_INTERRUPT_REQUEST_PIN_N]
         |=> !O_PIN_IS_FLAG[POS_INTERRUPT_REQUEST_PIN_N])
      else $error("pin claimed by flag bus without source bit");

   fixed_io_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      1'b1 |=> O_PIN_IS_FLAG[2:0] == 3'h7)
      else $error("general flag pins not owned by flag bus");

   output_drive_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      (cfg_bus.src[POS_TRIGGER_PIN1] && !cfg_bus.dir[POS_TRIGGER_PIN1])
      |=> (O_FLAG_PIN_OE[POS_TRIGGER_PIN1]
         && O_FLAG_PIN[POS_TRIGGER_PIN1] == $past(I_CH1_FLAGS[POS_TRIGGER_PIN1]
            & I_CH2_FLAGS[POS_TRIGGER_PIN1] ^ cfg_bus.pol[POS_TRIGGER_PIN1])
         && O_FLAG_BUS[POS_TRIGGER_PIN1] == $past(I_CH1_FLAGS[POS_TRIGGER_PIN1]
            & I_CH2_FLAGS[POS_TRIGGER_PIN1])))
      else $error("output flag pin not driven from internal flag");

   input_take_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      (cfg_bus.src[POS_TRIGGER_PIN1] && cfg_bus.dir[POS_TRIGGER_PIN1])
      |=> (!O_FLAG_PIN_OE[POS_TRIGGER_PIN1] && O_FLAG_BUS[POS_TRIGGER_PIN1] ==
         $past(filt[POS_TRIGGER_PIN1] ^ cfg_bus.pol[POS_TRIGGER_PIN1])))
      else $error("input flag not taken from filtered pin");

   pin_to_bus_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      (in_mode[POS_GENERAL_FLAG_PIN0] && !cfg_bus.pol[POS_GENERAL_FLAG_PIN0]
         && I_FLAG_PIN[POS_GENERAL_FLAG_PIN0]) [*8]
      |=> O_FLAG_BUS[POS_GENERAL_FLAG_PIN0])
      else $error("stable high pin never reached flag bus");

   oe_trig2_a: assert property (
      cfg_bus.src[4] && !cfg_bus.dir[4]
      |=> O_FLAG_PIN_OE[4])
      else $error("output flag not enabled on pin 4");

   oe_trig3_a: assert property (
      cfg_bus.src[5] && !cfg_bus.dir[5]
      |=> O_FLAG_PIN_OE[5])
      else $error("output flag not enabled on pin 5");

   oe_trig4_a: assert property (
      cfg_bus.src[6] && !cfg_bus.dir[6]
      |=> O_FLAG_PIN_OE[6])
      else $error("output flag not enabled on pin 6");

   oe_trig5_a: assert property (
      cfg_bus.src[7] && !cfg_bus.dir[7]
      |=> O_FLAG_PIN_OE[7])
      else $error("output flag not enabled on pin 7");

   oe_trig6_a: assert property (
      cfg_bus.src[8] && !cfg_bus.dir[8]
      |=> O_FLAG_PIN_OE[8])
      else $error("output flag not enabled on pin 8");

   oe_intr_a: assert property (
      cfg_bus.src[9] && !cfg_bus.dir[9]
      |=> O_FLAG_PIN_OE[9])
      else $error("output flag not enabled on pin 9");

   oe_amp1_a: assert property (
      cfg_bus.src[10] && !cfg_bus.dir[10]
      |=> O_FLAG_PIN_OE[10])
      else $error("output flag not enabled on pin 10");

   oe_amp2_a: assert property (
      cfg_bus.src[11] && !cfg_bus.dir[11]
      |=> O_FLAG_PIN_OE[11])
      else $error("output flag not enabled on pin 11");

   oe_trace_a: assert property (
      cfg_bus.src[12] && !cfg_bus.dir[12]
      |=> O_FLAG_PIN_OE[12])
      else $error("output flag not enabled on pin 12");

   oe_gen0_a: assert property (
      !cfg_bus.dir[0]
      |=> O_FLAG_PIN_OE[0])
      else $error("fixed flag pin 0 not driven as output");

   oe_gen1_a: assert property (
      !cfg_bus.dir[1]
      |=> O_FLAG_PIN_OE[1])
      else $error("fixed flag pin 1 not driven as output");

   oe_gen2_a: assert property (
      !cfg_bus.dir[2]
      |=> O_FLAG_PIN_OE[2])
      else $error("fixed flag pin 2 not driven as output");

   free_trig1_a: assert property (
      !cfg_bus.src[3]
      |=> !O_FLAG_PIN_OE[3] && !O_PIN_IS_FLAG[3])
      else $error("unrouted pin 3 taken by flag bus");

   free_trig2_a: assert property (
      !cfg_bus.src[4]
      |=> !O_FLAG_PIN_OE[4] && !O_PIN_IS_FLAG[4])
      else $error("unrouted pin 4 taken by flag bus");

   free_trig3_a: assert property (
      !cfg_bus.src[5]
      |=> !O_FLAG_PIN_OE[5] && !O_PIN_IS_FLAG[5])
      else $error("unrouted pin 5 taken by flag bus");

   free_trig4_a: assert property (
      !cfg_bus.src[6]
      |=> !O_FLAG_PIN_OE[6] && !O_PIN_IS_FLAG[6])
      else $error("unrouted pin 6 taken by flag bus");

   free_trig5_a: assert property (
      !cfg_bus.src[7]
      |=> !O_FLAG_PIN_OE[7] && !O_PIN_IS_FLAG[7])
      else $error("unrouted pin 7 taken by flag bus");

   free_trig6_a: assert property (
      !cfg_bus.src[8]
      |=> !O_FLAG_PIN_OE[8] && !O_PIN_IS_FLAG[8])
      else $error("unrouted pin 8 taken by flag bus");

   own_trig1_a: assert property (
      cfg_bus.src[3]
      |=> O_PIN_IS_FLAG[3])
      else $error("routed pin 3 kept its own function");

   own_trig2_a: assert property (
      cfg_bus.src[4]
      |=> O_PIN_IS_FLAG[4])
      else $error("routed pin 4 kept its own function");

   own_trig3_a: assert property (
      cfg_bus.src[5]
      |=> O_PIN_IS_FLAG[5])
      else $error("routed pin 5 kept its own function");

   own_trig4_a: assert property (
      cfg_bus.src[6]
      |=> O_PIN_IS_FLAG[6])
      else $error("routed pin 6 kept its own function");

   own_trig5_a: assert property (
      cfg_bus.src[7]
      |=> O_PIN_IS_FLAG[7])
      else $error("routed pin 7 kept its own function");

   own_trig6_a: assert property (
      cfg_bus.src[8]
      |=> O_PIN_IS_FLAG[8])
      else $error("routed pin 8 kept its own function");

   own_intr_a: assert property (
      cfg_bus.src[9]
      |=> O_PIN_IS_FLAG[9])
      else $error("routed pin 9 kept its own function");

   own_amp1_a: assert property (
      cfg_bus.src[10]
      |=> O_PIN_IS_FLAG[10])
      else $error("routed pin 10 kept its own function");

   own_amp2_a: assert property (
      cfg_bus.src[11]
      |=> O_PIN_IS_FLAG[11])
      else $error("routed pin 11 kept its own function");

   own_trace_a: assert property (
      cfg_bus.src[12]
      |=> O_PIN_IS_FLAG[12])
      else $error("routed pin 12 kept its own function");

   and_gen0_a: assert property (
      !cfg_bus.dir[0]
      |=> O_FLAG_BUS[0] == $past(I_CH1_FLAGS[0] & I_CH2_FLAGS[0]))
      else $error("flag 0 not the AND of both channels");

   and_intr_a: assert property (
      !(cfg_bus.src[9] && cfg_bus.dir[9])
      |=> O_FLAG_BUS[9] == $past(I_CH1_FLAGS[9] & I_CH2_FLAGS[9]))
      else $error("flag 9 not the AND of both channels");

   and_amp2_a: assert property (
      !(cfg_bus.src[11] && cfg_bus.dir[11])
      |=> O_FLAG_BUS[11] == $past(I_CH1_FLAGS[11] & I_CH2_FLAGS[11]))
      else $error("flag 11 not the AND of both channels");

   pol_gen1_a: assert property (
      1'b1
      |=> O_FLAG_PIN[1] == $past((I_CH1_FLAGS[1] & I_CH2_FLAGS[1]) ^ cfg_bus.pol[1]))
      else $error("pin 1 level ignores polarity");

   pol_trig5_a: assert property (
      1'b1
      |=> O_FLAG_PIN[7] == $past((I_CH1_FLAGS[7] & I_CH2_FLAGS[7]) ^ cfg_bus.pol[7]))
      else $error("pin 7 level ignores polarity");

   in_gen2_a: assert property (
      cfg_bus.dir[2]
      |=> O_FLAG_BUS[2] == $past(filt[2] ^ cfg_bus.pol[2]))
      else $error("input flag 2 not taken from filtered pin");

   //////////////////////////////////////////////////////////////////////////////
   input_mode_c: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      in_mode[POS_AMPLIFIER_OUTPUT_PIN1] ##1 $changed(O_FLAG_BUS[POS_AMPLIFIER_OUTPUT_PIN1]));

   output_mode_c: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      O_FLAG_PIN_OE[POS_TRIGGER_PIN1] && O_FLAG_PIN[POS_TRIGGER_PIN1]);

   exchange_c: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
      O_FLAG_BUS[15]);

endmodule

// [test/flag_board_model.sv]
module flag_board_model
   import flag_pkg::*;
(
   input  wire logic [PIN_W-1:0] i_dut_pin,
   input  wire logic [PIN_W-1:0] i_dut_oe,
   input  wire logic [PIN_W-1:0] i_board_drive,
   output logic      [PIN_W-1:0] o_wire
);
   timeunit 1ns;
   timeprecision 1ns;
   // the board lets go of a pin while the block drives it, so no contention is modelled
   assign o_wire = (i_dut_oe & i_dut_pin) | (~i_dut_oe & i_board_drive);
endmodule

// [test/shared_flag_bus_pin_router_bench.sv]
module shared_flag_bus_pin_router_bench
   import flag_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0]  PART   = 8'h3C; // arbitrary value
   localparam logic [15:0] ID_EXP = {PART, 4'h2, 4'h7};
   logic        clk_sys = 1'b0;
   logic        rstn    = 1'b0;
   logic [15:0] ch1     = 16'h0000;
   logic [15:0] ch2     = 16'h0000;
   logic [15:0] wdata   = 16'h0000;
   logic [8:0]  addr    = 9'h000;
   logic        wr      = 1'b0;
   logic        rd      = 1'b0;
   logic        lock    = 1'b0;
   logic [12:0] drive   = 13'h0000;
   logic [15:0] bus;
   logic [15:0] rdata;
   logic        rvalid;
   logic [12:0] pin_out;
   logic [12:0] pin_oe;
   logic [12:0] is_flag;
   logic [12:0] pin_wire;
   logic [15:0] exp_q[$];
   int          n_fail     = 0;
   int          n_compared = 0;

   ////////////////////////////////////////////////////////////////////////////////
   flag_pin_router #(.PART_ID(PART), .LAYOUT_VER(4'h2), .ISV(4'h7)) u_dut (
      .I_CLK_SYS     (clk_sys),
      .I_RSTN        (rstn),
      .I_CH1_FLAGS   (ch1),
      .I_CH2_FLAGS   (ch2),
      .O_FLAG_BUS    (bus),
      .I_FLAG_PIN    (pin_wire),
      .O_FLAG_PIN    (pin_out),
      .O_FLAG_PIN_OE (pin_oe),
      .O_PIN_IS_FLAG (is_flag),
      .I_REG_ADDR    (addr),
      .I_REG_WR      (wr),
      .I_REG_WDATA   (wdata),
      .I_REG_RD      (rd),
      .I_DEV_LOCK    (lock),
      .O_REG_RDATA   (rdata),
      .O_REG_RVALID  (rvalid)
   );

   flag_board_model u_board (
      .i_dut_pin     (pin_out),
      .i_dut_oe      (pin_oe),
      .i_board_drive (drive),
      .o_wire        (pin_wire)
   );

   always #50 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] expd);
      n_compared++;
      if (seen !== expd) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask

   task automatic complete_run();
      if (n_fail == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // strobe lowered one edge later, so back-to-back calls leave a gap cycle
   task automatic wr_reg(input logic [8:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk_sys);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [8:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd   <= 1'b1;
      exp_q.push_back(v);
      @(posedge clk_sys);
      rd   <= 1'b0;
   endtask

   // reference for the shared bus from current channel, pin and config values
   function automatic logic [15:0] exp_bus(input logic [15:0] s, d, p);
      logic [15:0] inp;
      inp = s & d & 16'h1FFF;
      exp_bus = (inp & ({3'b000, drive} ^ p)) | (~inp & ch1 & ch2);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // read answers are taken half a cycle after the edge that launches them
   always @(negedge clk_sys) begin
      if (rvalid === 1'b1) begin
         if (exp_q.size() > 0) begin
            check(rdata, exp_q.pop_front());
         end else begin
            n_fail++;
            $display("Error at %0t: read data without a pending read", $time);
         end
      end
   end

   initial begin
      logic [15:0] s;
      logic [15:0] d;
      logic [15:0] p;
      int          ones;
      void'($urandom(28577));
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      check({3'b000, is_flag}, 16'h1207);
      check({3'b000, pin_oe}, 16'h0000);
      rd_reg(ADDR_DIR, 16'h1FFF);
      rd_reg(ADDR_SRC, 16'h1207);
      rd_reg(ADDR_POL, 16'h0000);
      rd_reg(ADDR_ID, ID_EXP);
      wr_reg(ADDR_ID, 16'hFFFF);
      rd_reg(ADDR_ID, ID_EXP);
      rd_reg(9'h1C0, 16'h0000);
      // pin 0 is an input flag by default: a two-cycle pulse must vanish
      for (int w = 2; w <= 3; w++) begin
         repeat (8) @(posedge clk_sys);
         drive[0] <= 1'b1;
         repeat (w) @(posedge clk_sys);
         drive[0] <= 1'b0;
         ones = 0;
         repeat (12) begin
            @(negedge clk_sys);
            ones += int'(bus[0] === 1'b1);
         end
         check(16'(ones), (w == 3) ? 16'h0003 : 16'h0000);
      end
      lock <= 1'b1;
      wr_reg(ADDR_DIR, 16'h0000);
      wr_reg(ADDR_SRC, 16'h0000);
      rd_reg(ADDR_DIR, 16'h1FFF);
      rd_reg(ADDR_SRC, 16'h1207);
      lock <= 1'b0;
      // random routing, direction, polarity, channel flags and board levels
      for (int k = 0; k < 24; k++) begin
         s = 16'($urandom());
         d = 16'($urandom());
         p = 16'($urandom());
         wr_reg(ADDR_SRC, s);
         wr_reg(ADDR_DIR, d);
         wr_reg(ADDR_POL, p);
         s = (s & SRC_MASK) | FIXED_IO_MASK;
         d = d & DIR_MASK;
         p = p & POL_MASK;
         rd_reg(ADDR_SRC, s);
         rd_reg(ADDR_DIR, d);
         rd_reg(ADDR_POL, p);
         ch1   <= 16'($urandom());
         ch2   <= 16'($urandom());
         drive <= 13'($urandom());
         repeat (9) @(posedge clk_sys);
         @(negedge clk_sys);
         check({3'b000, is_flag}, s & 16'h1FFF);
         check({3'b000, pin_oe}, s & ~d & 16'h1FFF);
         check(bus, exp_bus(s, d, p));
         check({3'b000, pin_out & pin_oe}, ((ch1 & ch2) ^ p) & {3'b000, pin_oe});
      end
      for (int t = 0; t < 20 && exp_q.size() > 0; t++) begin
         @(posedge clk_sys);
      end
      if (exp_q.size() > 0) begin
         n_fail++;
         $display("Error at %0t: reads left unanswered", $time);
      end
      complete_run();
   end
endmodule
